/* envt_timer.sv */
/*
 envelope timer: 12-bit reloading down-counter with envelope output,
 sensor converter control and an ahb-lite register slave.
 assumes carrier and port inputs are asynchronous pins, one clock domain.
*/
`timescale 1ns/10ps
`include "envt_regs.svh"

// How it works
// - the count is 12 bits and drops by one on each selected tick.
// - a two-bit field picks osc, osc/4, osc/64 or the carrier as tick.
// - on overflow the count reloads from the stored reload value and the flag sets.
// - a tick while the count is 000 is the overflow; the count reloads instead of going to FFF.
// - control bit 7 runs the counter; zero holds it.
// - control bit 6 takes the tick from port C bit 7 instead.
// - control bit 0 enables the second envelope mode.
// - low data writes store the reload low byte; reads give the count low byte.
// - high data bits 3:0 store the reload nibble; reads give the count nibble.
// - in the second mode high data bit 7 sets mark (1) or space (0).
// - the converter works only while its control bit 3 is set.
// - converter bits 2:0 each enable one sensor drive port.
// - original mode on carrier tick toggles the envelope at each overflow.
// - on an oscillator tick the carrier run bit gates the output directly.
module envt_timer
   import envt_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic carrier_clock_source,
   input wire logic carrier_timer_run,
   input wire logic port_c7_in,
   output logic infrared_output_pin,
   output logic [2:0] sensor_port_enables,
   output logic envelope_overflow_event,
   output logic irq
);

   // ==========================================================
   // bus slave
   envt_ahb_req_t req_r;
   logic [7:0] conv_ctrl_r;
   logic [7:0] tmr_ctrl_r;
   logic [7:0] reload_low_byte;
   logic [7:0] high_reg_r;
   logic [11:0] cnt_r;
   logic flag_r;
   logic mask_r;
   logic ovf;
   logic wr_en;
   logic [7:0] wd;

   assign wr_en = req_r.valid & req_r.write;
   assign wd = hwdata[7:0];

   // capture the address phase; single zero-wait-state slave
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_r <= '0;
      end else if (hready) begin
         req_r.valid <= hsel & htrans[1] & (haddr[1:0] == 2'h0);
         req_r.write <= hwrite;
         req_r.idx <= haddr[9:2];
      end
   end

   // always ready and okay; reads answer in the data phase cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // read data registered from the address phase so data is ready at once
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr[9:2] == `ENVT_IDX_CONV_CTRL) begin
            hrdata <= {24'h000000, conv_ctrl_r};
         end else if (haddr[9:2] == `ENVT_IDX_TMR_CTRL) begin
            hrdata <= {24'h000000, tmr_ctrl_r};
         end else if (haddr[9:2] == `ENVT_IDX_CNT_LOW) begin
            hrdata <= {24'h000000, cnt_r[7:0]};
         end else if (haddr[9:2] == `ENVT_IDX_CNT_HIGH) begin
            hrdata <= {24'h000000, high_reg_r[7:4], cnt_r[11:8]};
         end else if (haddr[9:2] == `ENVT_IDX_IRQ_STAT) begin
            hrdata <= {31'h00000000, flag_r};
         end else if (haddr[9:2] == `ENVT_IDX_IRQ_MASK) begin
            hrdata <= {31'h00000000, mask_r};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // control registers; reserved bits are kept but drive nothing
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_ctrl_r <= `ENVT_RST_CTRL;
         tmr_ctrl_r <= `ENVT_RST_CTRL;
         reload_low_byte <= `ENVT_RST_CTRL;
         high_reg_r <= `ENVT_RST_CTRL;
         mask_r <= 1'b0;
      end else if (wr_en) begin
         if (req_r.idx == `ENVT_IDX_CONV_CTRL) begin
            conv_ctrl_r <= wd;
         end else if (req_r.idx == `ENVT_IDX_TMR_CTRL) begin
            tmr_ctrl_r <= wd;
         end else if (req_r.idx == `ENVT_IDX_CNT_LOW) begin
            reload_low_byte <= wd;
         end else if (req_r.idx == `ENVT_IDX_CNT_HIGH) begin
            high_reg_r <= wd;
         end else if (req_r.idx == `ENVT_IDX_IRQ_MASK) begin
            mask_r <= wd[0];
         end
      end
   end

   logic run;
   logic from_port;
   envt_src_t csel;
   logic mode2;
   assign run = tmr_ctrl_r[`ENVT_RUN_BIT];
   assign from_port = tmr_ctrl_r[`ENVT_PORTCLK_BIT];
   assign csel = envt_src_t'(tmr_ctrl_r[`ENVT_CSEL_HI:`ENVT_CSEL_LO]);
   assign mode2 = tmr_ctrl_r[`ENVT_MODE2_BIT];

   // ==========================================================
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   logic [2:0] car_s_r;
   logic [2:0] port_s_r;
   logic [2:0] crun_s_r;
   logic car_q_r;
   logic port_q_r;
   logic crun_q_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         car_s_r <= 3'h0;
         port_s_r <= 3'h0;
         crun_s_r <= 3'h0;
      end else begin
         car_s_r <= {car_s_r[1:0], carrier_clock_source};
         port_s_r <= {port_s_r[1:0], port_c7_in};
         crun_s_r <= {crun_s_r[1:0], carrier_timer_run};
      end
   end

   // filtered levels; a disagreement keeps the previous value
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         car_q_r <= 1'b0;
         port_q_r <= 1'b0;
         crun_q_r <= 1'b0;
      end else begin
         if (car_s_r[1] == car_s_r[2]) car_q_r <= car_s_r[2];
         if (port_s_r[1] == port_s_r[2]) port_q_r <= port_s_r[2];
         if (crun_s_r[1] == crun_s_r[2]) crun_q_r <= crun_s_r[2];
      end
   end

   logic car_rise;
   logic port_rise;
   assign car_rise = (car_s_r[1] == car_s_r[2]) & car_s_r[2] & ~car_q_r;
   assign port_rise = (port_s_r[1] == port_s_r[2]) & port_s_r[2]
      & ~port_q_r;

   // ==========================================================
   // oscillator prescaler; free-running so ticks need no restart
   logic [5:0] pre_r;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_r <= 6'h00;
      end else begin
         pre_r <= pre_r + 6'h01;
      end
   end

   // tick selection
   logic tick;
   always_comb begin
      if (from_port) begin
         // port input only counts while the converter is enabled
         tick = port_rise & conv_ctrl_r[`ENVT_CONV_EN_BIT];
      end else begin
         case (csel)
            ENVT_SRC_OSC: tick = 1'b1;
            ENVT_SRC_DIV4: tick = ((pre_r & `ENVT_DIV4) == `ENVT_DIV4);
            ENVT_SRC_DIV64: tick = (pre_r == `ENVT_DIV64);
            default: tick = car_rise;
         endcase
      end
   end

   // ==========================================================
   // counter
   assign ovf = run & tick & (cnt_r == 12'h000);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= `ENVT_RST_CNT;
      end else if (run && tick) begin
         if (cnt_r == 12'h000) begin
            cnt_r <= {high_reg_r[3:0], reload_low_byte};
         end else begin
            cnt_r <= cnt_r - 12'h001;
         end
      end
   end

   // sticky flag; a new overflow beats a same-cycle clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else if (ovf) begin
         flag_r <= 1'b1;
      end else if (wr_en && req_r.idx == `ENVT_IDX_IRQ_STAT && wd[0]) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
         envelope_overflow_event <= 1'b0;
      end else begin
         irq <= (flag_r | ovf) & mask_r;
         envelope_overflow_event <= ovf;
      end
   end

   // ==========================================================
   // envelope: toggles per overflow, or mark bit in mode 2
   logic env_r;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         env_r <= 1'b0;
      end else if (!run) begin
         env_r <= 1'b0;
      end else if (mode2) begin
         // bit sampled as written; software refreshes it per overflow
         env_r <= high_reg_r[`ENVT_MARK_BIT];
      end else if (ovf) begin
         env_r <= ~env_r;
      end
   end

   logic car_mode;
   assign car_mode = ~from_port & (csel == ENVT_SRC_CARRIER);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         infrared_output_pin <= 1'b0;
      end else if (car_mode && run) begin
         infrared_output_pin <= env_r & car_q_r;
      end else begin
         infrared_output_pin <= crun_q_r & car_q_r;
      end
   end

   // sensor drive enables only while the converter is on
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sensor_port_enables <= 3'h0;
      end else begin
         sensor_port_enables <= conv_ctrl_r[2:0]
            & {3{conv_ctrl_r[`ENVT_CONV_EN_BIT]}};
      end
   end

   // ==========================================================
   // checks
   property p_reload;
      @(posedge core_clk) disable iff (sys_rst)
      ovf |=> cnt_r == {$past(high_reg_r[3:0]), $past(reload_low_byte)};
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");

   property p_dec;
      @(posedge core_clk) disable iff (sys_rst)
      (run && tick && cnt_r != 12'h000) |=> cnt_r == $past(cnt_r) - 12'h001;
   endproperty
   a_dec: assert property (p_dec) else $error("bad decrement");

   property p_hold;
      @(posedge core_clk) disable iff (sys_rst)
      !run |=> cnt_r == $past(cnt_r);
   endproperty
   a_hold: assert property (p_hold) else $error("ran while stopped");

   property p_flag;
      @(posedge core_clk) disable iff (sys_rst)
      ovf |=> flag_r && irq == $past(mask_r);
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set");

   property p_wrap;
      @(posedge core_clk) disable iff (sys_rst)
      (run && tick && cnt_r == 12'h000) |=> envelope_overflow_event && flag_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap missed");

   sequence s_toggle;
      ovf && run && !mode2;
   endsequence
   property p_toggle;
      @(posedge core_clk) disable iff (sys_rst)
      s_toggle |=> env_r != $past(env_r);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");

   property p_mark;
      @(posedge core_clk) disable iff (sys_rst)
      (run && mode2) |=> env_r == $past(high_reg_r[7]);
   endproperty
   a_mark: assert property (p_mark) else $error("mark wrong");

   property p_sense;
      @(posedge core_clk) disable iff (sys_rst)
      !conv_ctrl_r[3] |=> sensor_port_enables == 3'h0;
   endproperty
   a_sense: assert property (p_sense) else $error("port on");

   property p_portclk;
      @(posedge core_clk) disable iff (sys_rst)
      (from_port && !conv_ctrl_r[3]) |-> !tick;
   endproperty
   a_portclk: assert property (p_portclk) else $error("port tick");

endmodule

/* envt_regs.svh */
/*
 envelope timer register map, field positions, reset values and counts.
 assumes an ahb-lite slave with one aligned 32-bit word per register.
*/
`ifndef ENVT_REGS_SVH
`define ENVT_REGS_SVH
// printed offsets are register indices; byte address is four times them
`define ENVT_IDX_CONV_CTRL 8'h1E
`define ENVT_IDX_TMR_CTRL 8'h22
`define ENVT_IDX_CNT_LOW 8'h25
`define ENVT_IDX_CNT_HIGH 8'h26
`define ENVT_IDX_IRQ_STAT 8'h30
`define ENVT_IDX_IRQ_MASK 8'h31
// control register fields
`define ENVT_RUN_BIT 7
`define ENVT_PORTCLK_BIT 6
`define ENVT_CSEL_HI 5
`define ENVT_CSEL_LO 4
`define ENVT_MODE2_BIT 0
`define ENVT_MARK_BIT 7
`define ENVT_CONV_EN_BIT 3
// reset values
`define ENVT_RST_CTRL 8'h00
`define ENVT_RST_CNT 12'h000
// oscillator divide counts
`define ENVT_DIV4 6'h03
`define ENVT_DIV64 6'h3F
`define ENVT_CNT_MAX 12'hFFF
`endif

/* envt_pkg.sv */
/*
 types shared by the envelope timer.
 assumes envt_regs.svh is available on the include path.
*/
package envt_pkg;
   // ahb address phase captured for the data phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] idx;
   } envt_ahb_req_t;
   // counter clock sources
   typedef enum logic [1:0] {
      ENVT_SRC_OSC = 2'h0,
      ENVT_SRC_DIV4 = 2'h1,
      ENVT_SRC_DIV64 = 2'h2,
      ENVT_SRC_CARRIER = 2'h3
   } envt_src_t;
endpackage

/* envt_far_model.sv */
/*
 far-side model: timer a carrier pin and the rc sensor oscillator.
 assumes a 100 ns core clock; edges are skewed off the core edges.
*/
`timescale 1ns/10ps
module envt_far_model (
   output logic carrier_clock_source,
   output logic port_c7_in,
   input wire logic [2:0] sensor_port_enables
);
   // ======================================
   // carrier: free running, 800 ns period
   initial begin
      carrier_clock_source = 1'b0;
      #30;
      forever #400 carrier_clock_source = ~carrier_clock_source;
   end
   // rc oscillator: 1 us period, only while a drive port is enabled;
   // with no resistor driven the capacitor discharges, so it rests low
   initial begin
      port_c7_in = 1'b0;
      #70;
      forever begin
         #500;
         port_c7_in = (|sensor_port_enables) ? ~port_c7_in : 1'b0;
      end
   end
endmodule

/* test_envt_timer.sv */
/*
 self-checking bench for the envelope timer over ahb-lite.
 assumes the far-side model drives the carrier and port c7 pins.
*/
`timescale 1ns/10ps
module test_envt_timer
   import envt_pkg::*;
;
   localparam logic [31:0] A_CONV = 32'h78, A_CTRL = 32'h88;
   localparam logic [31:0] A_LOW = 32'h94, A_HIGH = 32'h98;
   localparam logic [31:0] A_STAT = 32'hC0, A_MASK = 32'hC4;
   logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq;
   logic carrier_clock_source, carrier_timer_run, port_c7_in;
   logic infrared_output_pin, envelope_overflow_event;
   logic [31:0] haddr, hwdata, hrdata, rd, rd2;
   logic [1:0] htrans;
   logic [2:0] hsize, sensor_port_enables;
   int fail_count = 0, checked = 0, cyc, hi, hi2;
   int per[4] = '{1, 4, 64, 8};
   logic [31:0] regs[6] = '{A_CONV, A_CTRL, A_LOW, A_HIGH, A_STAT, A_MASK};
   envt_timer envt_timer_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .carrier_clock_source(carrier_clock_source),
      .carrier_timer_run(carrier_timer_run), .port_c7_in(port_c7_in),
      .infrared_output_pin(infrared_output_pin),
      .sensor_port_enables(sensor_port_enables),
      .envelope_overflow_event(envelope_overflow_event), .irq(irq));
   envt_far_model envt_far_model_i (
      .carrier_clock_source(carrier_clock_source),
      .port_c7_in(port_c7_in), .sensor_port_enables(sensor_port_enables));
   // ======================================
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      #(100 * 20000);
      fail_count++;
      stop_test();
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one single transfer; the master waits as long as hready says
   task automatic bus(input logic w, input logic [31:0] a, wd,
                      output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, wd);
      logic [31:0] d;
      bus(1'b1, a, wd, d);
   endtask
   task automatic rdr(input logic [31:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   // edges from one overflow pulse to the next, and cycles with the output pin high
   task automatic meas(output int c, output int h);
      int n;
      n = 0;
      c = 1;
      h = 0;
      while (envelope_overflow_event !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 5000) fail_count++;
      @(posedge core_clk);
      while (envelope_overflow_event !== 1'b1 && c < 5000) begin
         if (infrared_output_pin === 1'b1) h++;
         c++;
         @(posedge core_clk);
      end
   endtask
   task automatic cnt_hi(output int h);
      h = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (infrared_output_pin === 1'b1) h++;
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ======================================
   // test sequence
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      carrier_timer_run = 1'b0;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) begin
         rdr(regs[i], rd);
         chk("reset value", rd, 32'h0);
      end
      chk("bus response", 32'(hresp), 32'h0);
      wr(32'h40, 32'hFF);
      rdr(32'h40, rd);
      chk("unmapped read", rd, 32'h0);
      wr(A_CTRL, 32'h0C);
      rdr(A_CTRL, rd);
      chk("reserved ctrl", rd, 32'h0C);
      for (int b = 0; b < 3; b++) begin
         wr(A_CONV, 32'h08 | (32'h1 << b));
         repeat (2) @(posedge core_clk);
         chk("drive enable", 32'(sensor_port_enables), 32'h1 << b);
      end
      wr(A_CONV, 32'hF7);
      repeat (2) @(posedge core_clk);
      chk("converter off", 32'(sensor_port_enables), 32'h0);
      rdr(A_CONV, rd);
      chk("reserved conv", rd, 32'hF7);
      // reload 5 gives six ticks per overflow on every source
      wr(A_LOW, 32'h05);
      wr(A_HIGH, 32'h00);
      foreach (per[i]) begin
         wr(A_CTRL, 32'h80 | (i << 4));
         meas(cyc, hi);
         chk("overflow period", cyc, 6 * per[i]);
      end
      wr(A_CONV, 32'h09);
      wr(A_CTRL, 32'hC0);
      meas(cyc, hi);
      chk("port period", cyc, 60);
      wr(A_CTRL, 32'hB0);
      meas(cyc, hi);
      meas(cyc, hi2);
      chk("envelope toggles", (hi > 8) ^ (hi2 > 8), 1);
      wr(A_HIGH, 32'h80);
      wr(A_CTRL, 32'hB1);
      meas(cyc, hi);
      meas(cyc, hi2);
      chk("mark held", (hi > 8) && (hi2 > 8), 1);
      wr(A_HIGH, 32'h00);
      meas(cyc, hi);
      chk("space", hi > 8, 0);
      wr(A_CTRL, 32'h80);
      carrier_timer_run <= 1'b1;
      cnt_hi(hi);
      chk("carrier gated on", hi > 8, 1);
      carrier_timer_run <= 1'b0;
      repeat (8) @(posedge core_clk);
      cnt_hi(hi);
      chk("carrier gated off", hi, 0);
      rdr(A_STAT, rd);
      chk("flag set", rd, 32'h1);
      chk("irq masked", 32'(irq), 32'h0);
      wr(A_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq raised", 32'(irq), 32'h1);
      wr(A_CTRL, 32'h00);
      wr(A_STAT, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq cleared", 32'(irq), 32'h0);
      rdr(A_STAT, rd);
      chk("flag cleared", rd, 32'h0);
      // live count reads back, not the stored reload
      wr(A_LOW, 32'h23);
      wr(A_HIGH, 32'h01);
      wr(A_CTRL, 32'h80);
      repeat (10) @(posedge core_clk);
      wr(A_CTRL, 32'h00);
      rdr(A_LOW, rd);
      rdr(A_HIGH, rd2);
      chk("count low", rd > 32'h08 && rd < 32'h23, 1);
      chk("count high", 32'(rd2[3:0]), 32'h1);
      repeat (5) @(posedge core_clk);
      rdr(A_LOW, rd2);
      chk("count held", rd2, rd);
      stop_test();
   end
endmodule
